// *** rtl/sfp_pkg.sv ***
// constants shared by the sample buffer and its host access port
// assumes one core clock and a separate host link clock
//
// Overview of operation
// - store 512 entries: 170 three-axis sets or 128 sets with temperature
// - mode 00 stores nothing and empties the buffer
// - mode 01 fills until full, then accepts only as reads free room
// - mode 10 keeps newest entries, dropping the oldest when full
// - watermark interrupt raised once stored count reaches the threshold
// - mode 11 captures once around activity, pre-event count from threshold
// - entry is 16 bits, low byte first, bits 13:12 repeat sign
// - top two bits tag source: x, y, z, temperature
// - buffer bursts unlimited; bytes after empty read as zero
// - each set written x, y, z, then optional temperature
// - partial sets may be stored when room runs short
// - each read entry frees its space at once
// - each pin is the or of conditions in its route register
// - pin with nothing routed, or in reset, is not driven
// - pins active high, active low when polarity bit set
// - status read clears activity and inactivity flags
// - data register reads clear the data ready flag
// - buffer flags clear once reads end their conditions
// - watermark flag bit 2 tracks count against threshold
// - buffer ready flag bit 1 set while any entry is held
// - overrun flag bit 3 set on loss, cleared by reads or disable
// - pin in alternate input use drives no interrupt
package sfp_pkg;
  // =====================================================
  // sizes
  localparam int FIFO_DEPTH = 512;
  localparam int SETS_XYZ   = 170;
  localparam int SETS_XYZT  = 128;
  // =====================================================
  // register offsets
  localparam logic [7:0] ADDR_FLAGS   = 8'h0b;
  localparam logic [7:0] ADDR_CTRL    = 8'h28;
  localparam logic [7:0] ADDR_THR     = 8'h29;
  localparam logic [7:0] ADDR_ROUTE_A = 8'h2a;
  localparam logic [7:0] ADDR_ROUTE_B = 8'h2b;
  localparam logic [7:0] ADDR_DAT1_LO = 8'h08;
  localparam logic [7:0] ADDR_DAT1_HI = 8'h0a;
  localparam logic [7:0] ADDR_DAT2_LO = 8'h0e;
  localparam logic [7:0] ADDR_DAT2_HI = 8'h15;
  // =====================================================
  // field positions
  localparam int CTRL_TEMP_BIT = 2;
  localparam int CTRL_HIGH_BIT = 3;
  localparam int ROUTE_POL_BIT = 7;
  localparam int FLG_DRDY  = 0;
  localparam int FLG_RDY   = 1;
  localparam int FLG_WM    = 2;
  localparam int FLG_OVR   = 3;
  localparam int FLG_ACT   = 4;
  localparam int FLG_INACT = 5;
  localparam int FLG_AWAKE = 6;
  // =====================================================
  // reset values
  localparam logic [7:0] CTRL_RST  = 8'h00;
  localparam logic [7:0] THR_RST   = 8'h80;
  localparam logic [7:0] ROUTE_RST = 8'h00;
  // =====================================================
  // encodings
  typedef enum logic [1:0] {
    MODE_OFF    = 2'h0,
    MODE_OLDEST = 2'h1,
    MODE_STREAM = 2'h2,
    MODE_TRIG   = 2'h3
  } mode_e;
  localparam logic [1:0] TAG_X = 2'h0;
  localparam logic [1:0] TAG_Y = 2'h1;
  localparam logic [1:0] TAG_Z = 2'h2;
  localparam logic [1:0] TAG_T = 2'h3;
  typedef enum logic [1:0] {
    OP_REG_RD = 2'h0,
    OP_REG_WR = 2'h1,
    OP_BUF_RD = 2'h2
  } op_e;
endpackage

// *** rtl/bit_sync.sv ***
// two-flop synchroniser for independent level or toggle bits
// assumes each bit changes at most once per few destination clocks
module bit_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             i_clk,
  input  wire logic             i_rst,
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] sync_reg;

  // =====================================================
  // first stage read only by the second
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= i_async;
      sync_reg <= meta_reg;
    end
  end

  assign o_sync = sync_reg;
endmodule // bit_sync

// *** rtl/sample_fifo_and_irq_pins.sv ***
// sample buffer with tagged entries, status flags and two interrupt pins
// assumes sample inputs on the core clock; host access on its own link clock
module sample_fifo_and_irq_pins #(
  parameter int DEPTH = sfp_pkg::FIFO_DEPTH
) (
  input  wire logic        i_ref_clk,
  input  wire logic        i_rst,
  input  wire logic        i_sample_valid,
  input  wire logic [11:0] i_sample_x,
  input  wire logic [11:0] i_sample_y,
  input  wire logic [11:0] i_sample_z,
  input  wire logic [11:0] i_sample_t,
  input  wire logic        i_activity_event,
  input  wire logic        i_inactivity_event,
  input  wire logic        i_awake,
  input  wire logic        i_external_timebase_select,
  input  wire logic        i_external_trigger_select,
  output logic             o_irq_pin_a,
  output logic             o_irq_pin_a_oe,
  output logic             o_irq_pin_b,
  output logic             o_irq_pin_b_oe,
  input  wire logic        i_link_clk,
  input  wire logic        i_link_rst,
  input  wire logic        i_link_req,
  input  wire logic [1:0]  i_link_op,
  input  wire logic [7:0]  i_link_addr,
  input  wire logic [7:0]  i_link_wdata,
  output logic             o_link_busy,
  output logic             o_link_done,
  output logic [7:0]       o_link_rdata
);
  localparam int PW = $clog2(DEPTH);
  localparam int CW = PW + 1;
  localparam logic [CW-1:0] FULL = CW'(DEPTH);
  localparam int TW = (CW > 9) ? CW : 9; // small depths must not cut the threshold
  // =====================================================
  // link domain: capture request, toggle handshake
  logic       req_tgl_reg;
  logic       ack_seen_reg;
  logic       ack_sync;
  logic [1:0] hold_op_reg;
  logic [7:0] hold_addr_reg;
  logic [7:0] hold_wdata_reg;
  logic [7:0] link_rdata_reg;
  logic       link_done_reg;
  logic       ack_tgl_reg;
  logic [7:0] rdata_reg;

  // one access in flight; fields held until the answer returns
  always_ff @(posedge i_link_clk) begin
    if (i_link_rst) begin
      req_tgl_reg    <= 1'b0;
      hold_op_reg    <= 2'h0;
      hold_addr_reg  <= 8'h00;
      hold_wdata_reg <= 8'h00;
    end else if (i_link_req && !o_link_busy) begin
      req_tgl_reg    <= ~req_tgl_reg;
      hold_op_reg    <= i_link_op;
      hold_addr_reg  <= i_link_addr;
      hold_wdata_reg <= i_link_wdata;
    end
  end

  // answer side: rdata is stable once ack toggle arrives
  always_ff @(posedge i_link_clk) begin
    if (i_link_rst) begin
      ack_seen_reg   <= 1'b0;
      link_done_reg  <= 1'b0;
      link_rdata_reg <= 8'h00;
    end else begin
      link_done_reg <= ack_sync ^ ack_seen_reg;
      ack_seen_reg  <= ack_sync;
      if (ack_sync ^ ack_seen_reg) begin
        link_rdata_reg <= rdata_reg;
      end
    end
  end

  bit_sync #(.WIDTH(1)) u_ack_sync (
    .i_clk   (i_link_clk),
    .i_rst   (i_link_rst),
    .i_async (ack_tgl_reg),
    .o_sync  (ack_sync)
  );

  assign o_link_busy  = req_tgl_reg ^ ack_seen_reg;
  assign o_link_done  = link_done_reg;
  assign o_link_rdata = link_rdata_reg;

  // =====================================================
  // core domain: request decode
  logic req_sync;
  logic req_seen_reg;
  logic acc_go;
  logic reg_rd;
  logic reg_wr;
  logic buf_rd;

  bit_sync #(.WIDTH(1)) u_req_sync (
    .i_clk   (i_ref_clk),
    .i_rst   (i_rst),
    .i_async (req_tgl_reg),
    .o_sync  (req_sync)
  );

  // held fields are read only after the toggle has settled
  assign acc_go = req_sync ^ req_seen_reg;
  assign reg_rd = acc_go && (hold_op_reg == sfp_pkg::OP_REG_RD);
  assign reg_wr = acc_go && (hold_op_reg == sfp_pkg::OP_REG_WR);
  assign buf_rd = acc_go && (hold_op_reg == sfp_pkg::OP_BUF_RD);

  // =====================================================
  // registers
  logic [7:0] ctrl_reg;
  logic [7:0] thr_reg;
  logic [7:0] route_reg [2];
  sfp_pkg::mode_e mode;
  logic       temp_en;
  logic [TW-1:0] thresh;

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      ctrl_reg     <= sfp_pkg::CTRL_RST;
      thr_reg      <= sfp_pkg::THR_RST;
      route_reg[0] <= sfp_pkg::ROUTE_RST;
      route_reg[1] <= sfp_pkg::ROUTE_RST;
    end else if (reg_wr) begin
      case (hold_addr_reg)
        sfp_pkg::ADDR_CTRL:    ctrl_reg     <= hold_wdata_reg;
        sfp_pkg::ADDR_THR:     thr_reg      <= hold_wdata_reg;
        sfp_pkg::ADDR_ROUTE_A: route_reg[0] <= hold_wdata_reg;
        sfp_pkg::ADDR_ROUTE_B: route_reg[1] <= hold_wdata_reg;
        default: ;
      endcase
    end
  end

  assign mode    = sfp_pkg::mode_e'(ctrl_reg[1:0]);
  assign temp_en = ctrl_reg[sfp_pkg::CTRL_TEMP_BIT];
  assign thresh  = TW'({ctrl_reg[sfp_pkg::CTRL_HIGH_BIT], thr_reg});

  // =====================================================
  // set writer: one entry per cycle, gray along the path except S_T back to S_IDLE
  typedef enum logic [2:0] {
    S_IDLE = 3'h0,
    S_X    = 3'h1,
    S_Y    = 3'h3,
    S_Z    = 3'h2,
    S_T    = 3'h6
  } wr_state_e;
  wr_state_e  st_reg;
  logic [11:0] smp_reg [4];
  logic        push;
  logic [1:0]  tag;
  logic [15:0] entry;

  // a new sample during an unfinished set is ignored; sets are slow
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      st_reg <= S_IDLE;
    end else begin
      case (st_reg)
        S_IDLE: begin
          if (i_sample_valid && mode != sfp_pkg::MODE_OFF) begin
            st_reg <= S_X;
          end
        end
        S_X: st_reg <= S_Y;
        S_Y: st_reg <= S_Z;
        S_Z: st_reg <= temp_en ? S_T : S_IDLE;
        S_T: st_reg <= S_IDLE;
        default: st_reg <= S_IDLE;
      endcase
    end
  end

  // sample capture, datapath only
  always_ff @(posedge i_ref_clk) begin
    if (st_reg == S_IDLE && i_sample_valid) begin
      smp_reg[0] <= i_sample_x;
      smp_reg[1] <= i_sample_y;
      smp_reg[2] <= i_sample_z;
      smp_reg[3] <= i_sample_t;
    end
  end

  assign push = (st_reg != S_IDLE) && (mode != sfp_pkg::MODE_OFF);

  always_comb begin
    case (st_reg)
      S_Y:     tag = sfp_pkg::TAG_Y;
      S_Z:     tag = sfp_pkg::TAG_Z;
      S_T:     tag = sfp_pkg::TAG_T;
      default: tag = sfp_pkg::TAG_X;
    endcase
  end

  assign entry = {tag, {2{smp_reg[tag][11]}}, smp_reg[tag]};

  // =====================================================
  // storage and occupancy
  // entry array, 512 deep by default
  logic [15:0]   mem [DEPTH];
  logic [PW-1:0] wr_ptr_reg;
  logic [PW-1:0] rd_ptr_reg;
  logic [CW-1:0] count_reg;
  logic          byte_hi_reg;
  logic          trig_seen_reg;
  logic          pop;
  logic [CW-1:0] cnt_after_pop;
  logic          do_write;
  logic          do_drop;
  logic          ovr_set;

  // one entry freed per completed word read
  assign pop = buf_rd && byte_hi_reg && (count_reg != '0);
  assign cnt_after_pop = count_reg - CW'(pop);

  // per-mode admission of the entry being pushed
  always_comb begin
    do_write = 1'b0;
    do_drop  = 1'b0;
    ovr_set  = 1'b0;
    if (push) begin
      case (mode)
        // stop when full, refuse and flag
        sfp_pkg::MODE_OLDEST: begin
          if (cnt_after_pop < FULL) begin
            do_write = 1'b1;
          end else begin
            ovr_set = 1'b1;
          end
        end
        sfp_pkg::MODE_STREAM: begin
          do_write = 1'b1;
          if (cnt_after_pop == FULL) begin
            do_drop = 1'b1;
            ovr_set = 1'b1;
          end
        end
        sfp_pkg::MODE_TRIG: begin
          if (!trig_seen_reg) begin
            do_write = 1'b1;
            do_drop  = (cnt_after_pop != '0) &&
                       (TW'(cnt_after_pop) >= thresh || cnt_after_pop == FULL);
          end else if (cnt_after_pop < FULL) begin
            do_write = 1'b1;
          end else begin
            ovr_set = 1'b1;
          end
        end
        default: ;
      endcase
    end
  end

  // partial sets fall out of per-entry admission
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else if (mode == sfp_pkg::MODE_OFF) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else begin
      wr_ptr_reg <= wr_ptr_reg + PW'(do_write);
      rd_ptr_reg <= rd_ptr_reg + PW'(pop) + PW'(do_drop);
      count_reg  <= cnt_after_pop + CW'(do_write) - CW'(do_drop);
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (do_write) begin
      mem[wr_ptr_reg] <= entry;
    end
  end

  // trigger is one-shot; rearmed by any control write
  always_ff @(posedge i_ref_clk) begin
    if (i_rst || reg_wr && hold_addr_reg == sfp_pkg::ADDR_CTRL) begin
      trig_seen_reg <= 1'b0;
    end else if (mode == sfp_pkg::MODE_TRIG && i_activity_event) begin
      trig_seen_reg <= 1'b1;
    end
  end

  // low byte first, pairing kept across buffer reads
  always_ff @(posedge i_ref_clk) begin
    if (i_rst || mode == sfp_pkg::MODE_OFF) begin
      byte_hi_reg <= 1'b0;
    end else if (buf_rd) begin
      byte_hi_reg <= ~byte_hi_reg;
    end
  end

  // =====================================================
  // status flags
  logic       drdy_reg;
  logic       act_reg;
  logic       inact_reg;
  logic       ovr_reg;
  logic       data_rd;
  logic [7:0] flags;

  assign data_rd = reg_rd &&
    ((hold_addr_reg >= sfp_pkg::ADDR_DAT1_LO && hold_addr_reg <= sfp_pkg::ADDR_DAT1_HI) ||
     (hold_addr_reg >= sfp_pkg::ADDR_DAT2_LO && hold_addr_reg <= sfp_pkg::ADDR_DAT2_HI));

  // sticky events: a set in the clearing cycle wins
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      drdy_reg  <= 1'b0;
      act_reg   <= 1'b0;
      inact_reg <= 1'b0;
    end else begin
      drdy_reg  <= i_sample_valid | (drdy_reg & ~data_rd);
      act_reg   <= i_activity_event |
                   (act_reg & ~(reg_rd && hold_addr_reg == sfp_pkg::ADDR_FLAGS));
      inact_reg <= i_inactivity_event |
                   (inact_reg & ~(reg_rd && hold_addr_reg == sfp_pkg::ADDR_FLAGS));
    end
  end

  // overrun: loss sets, read or disable clears
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      ovr_reg <= 1'b0;
    end else if (ovr_set) begin
      ovr_reg <= 1'b1;
    end else if (pop || mode == sfp_pkg::MODE_OFF) begin
      ovr_reg <= 1'b0;
    end
  end

  always_comb begin
    flags = 8'h00;
    flags[sfp_pkg::FLG_DRDY]  = drdy_reg;
    flags[sfp_pkg::FLG_RDY]   = count_reg != '0;
    flags[sfp_pkg::FLG_WM]    = TW'(count_reg) >= thresh;
    flags[sfp_pkg::FLG_OVR]   = ovr_reg;
    flags[sfp_pkg::FLG_ACT]   = act_reg;
    flags[sfp_pkg::FLG_INACT] = inact_reg;
    flags[sfp_pkg::FLG_AWAKE] = i_awake;
  end

  // =====================================================
  // read answer and handshake return
  logic [15:0] head;

  assign head = mem[rd_ptr_reg];

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      rdata_reg    <= 8'h00;
      req_seen_reg <= 1'b0;
      ack_tgl_reg  <= 1'b0;
    end else begin
      req_seen_reg <= req_sync;
      if (acc_go) begin
        ack_tgl_reg <= req_sync;
      end
      if (buf_rd) begin
        if (count_reg == '0) begin
          rdata_reg <= 8'h00;
        end else begin
          rdata_reg <= byte_hi_reg ? head[15:8] : head[7:0];
        end
      end else if (reg_rd) begin
        case (hold_addr_reg)
          sfp_pkg::ADDR_FLAGS:   rdata_reg <= flags;
          sfp_pkg::ADDR_CTRL:    rdata_reg <= ctrl_reg;
          sfp_pkg::ADDR_THR:     rdata_reg <= thr_reg;
          sfp_pkg::ADDR_ROUTE_A: rdata_reg <= route_reg[0];
          sfp_pkg::ADDR_ROUTE_B: rdata_reg <= route_reg[1];
          default:               rdata_reg <= 8'h00;
        endcase
      end
    end
  end

  // =====================================================
  // interrupt pins
  logic [1:0] alt_sel;
  logic [1:0] pin_reg;
  logic [1:0] pin_oe_reg;

  assign alt_sel = {i_external_trigger_select, i_external_timebase_select};

  // registered so the pins never glitch on flag decode
  always_ff @(posedge i_ref_clk) begin
    for (int i = 0; i < 2; i++) begin
      if (i_rst) begin
        pin_reg[i]    <= 1'b0;
        pin_oe_reg[i] <= 1'b0;
      end else begin
        // or of routed flags, polarity applied
        pin_reg[i]    <= (|(flags[6:0] & route_reg[i][6:0])) ^
                         route_reg[i][sfp_pkg::ROUTE_POL_BIT];
        // nothing routed or alternate use: released
        pin_oe_reg[i] <= (|route_reg[i][6:0]) && !alt_sel[i];
      end
    end
  end

  assign o_irq_pin_a    = pin_reg[0];
  assign o_irq_pin_a_oe = pin_oe_reg[0];
  assign o_irq_pin_b    = pin_reg[1];
  assign o_irq_pin_b_oe = pin_oe_reg[1];
endmodule // sample_fifo_and_irq_pins

// *** tb/sfp_chk.sv ***
// checker: pin release on reset and alternate use, link answers
// assumes it is bound into the top and sees only its ports
module sfp_chk (
  input wire logic       i_ref_clk,
  input wire logic       i_rst,
  input wire logic       i_external_timebase_select,
  input wire logic       i_external_trigger_select,
  input wire logic       o_irq_pin_a,
  input wire logic       o_irq_pin_a_oe,
  input wire logic       o_irq_pin_b,
  input wire logic       o_irq_pin_b_oe,
  input wire logic       i_link_clk,
  input wire logic       i_link_rst,
  input wire logic       i_link_req,
  input wire logic [1:0] i_link_op,
  input wire logic [7:0] i_link_addr,
  input wire logic       o_link_busy,
  input wire logic       o_link_done,
  input wire logic [7:0] o_link_rdata
);
  // ==========================================================
  // request kept from acceptance, to judge its answer
  logic [1:0] cap_op;
  logic [7:0] cap_addr;
  logic       is_dreg;
  always_ff @(posedge i_link_clk) begin
    if (i_link_req && !o_link_busy) begin
      cap_op   <= i_link_op;
      cap_addr <= i_link_addr;
    end
  end
  assign is_dreg = (cap_addr >= 8'h08 && cap_addr <= 8'h0a)
                || (cap_addr >= 8'h0e && cap_addr <= 8'h15);
  // ==========================================================
  // pins
  // released in reset
  property p_rst_a;
    @(posedge i_ref_clk) i_rst |=> !o_irq_pin_a_oe && !o_irq_pin_a;
  endproperty
  a_rst_a: assert property (p_rst_a) else $error("pin a driven after reset");
  property p_rst_b;
    @(posedge i_ref_clk) i_rst |=> !o_irq_pin_b_oe && !o_irq_pin_b;
  endproperty
  a_rst_b: assert property (p_rst_b) else $error("pin b driven after reset");
  property p_alt_a;
    @(posedge i_ref_clk) disable iff (i_rst)
      i_external_timebase_select [*5] |-> !o_irq_pin_a_oe;
  endproperty
  a_alt_a: assert property (p_alt_a) else $error("pin a driven in input use");
  property p_alt_b;
    @(posedge i_ref_clk) disable iff (i_rst)
      i_external_trigger_select [*5] |-> !o_irq_pin_b_oe;
  endproperty
  a_alt_b: assert property (p_alt_b) else $error("pin b driven in input use");
  // ==========================================================
  // link answers
  // every byte request answered
  property p_done_bound;
    @(posedge i_link_clk) disable iff (i_link_rst)
      $rose(o_link_busy) |-> ##[2:12] o_link_done;
  endproperty
  a_done_bound: assert property (p_done_bound) else $error("no answer in time");
  property p_done_pulse;
    @(posedge i_link_clk) disable iff (i_link_rst) o_link_done |=> !o_link_done;
  endproperty
  a_done_pulse: assert property (p_done_pulse) else $error("done too long");
  // each access ends with its answer
  property p_busy_end;
    @(posedge i_link_clk) disable iff (i_link_rst) $fell(o_link_busy) |-> o_link_done;
  endproperty
  a_busy_end: assert property (p_busy_end) else $error("busy ended silently");
  property p_dreg_zero;
    @(posedge i_link_clk) disable iff (i_link_rst)
      o_link_done && cap_op == sfp_pkg::OP_REG_RD && is_dreg |-> o_link_rdata == 8'h00;
  endproperty
  a_dreg_zero: assert property (p_dreg_zero) else $error("data register not zero");
endmodule // sfp_chk

bind sample_fifo_and_irq_pins sfp_chk sfp_chk_i (
  .i_ref_clk, .i_rst, .i_external_timebase_select, .i_external_trigger_select,
  .o_irq_pin_a, .o_irq_pin_a_oe, .o_irq_pin_b, .o_irq_pin_b_oe,
  .i_link_clk, .i_link_rst, .i_link_req, .i_link_op, .i_link_addr,
  .o_link_busy, .o_link_done, .o_link_rdata
);

// *** tb/sfp_host.sv ***
// host model: one link access at a time, buffer read by whole words
// assumes done is a one-cycle pulse and busy is low in the done cycle
module sfp_host (
  input  wire logic       i_link_clk,
  input  wire logic       i_done,
  input  wire logic [7:0] i_rdata,
  output logic            o_req,
  output logic [1:0]      o_op,
  output logic [7:0]      o_addr,
  output logic [7:0]      o_wdata
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    o_req   = 1'b0;
    o_op    = 2'h3;
    o_addr  = 8'h00;
    o_wdata = 8'h00;
  end
  // held until done; dropped before the next edge so no second take
  task automatic xfer(input logic [1:0] op, input logic [7:0] a, w, output logic [7:0] r);
    int n;
    @(posedge i_link_clk);
    #1;
    o_req   = 1'b1;
    o_op    = op;
    o_addr  = a;
    o_wdata = w;
    n = 0;
    do begin
      @(posedge i_link_clk);
      #1;
      n++;
    end while (i_done !== 1'b1 && n < 40);
    if (i_done !== 1'b1) test_sample_fifo_and_irq_pins.fails++;
    r = i_rdata;
    o_req = 1'b0;
    // released lines show the inverse
    o_op    = ~op;
    o_addr  = ~a;
    o_wdata = ~w;
  endtask
  task automatic word(output logic [15:0] v);
    logic [7:0] lo, hi;
    xfer(sfp_pkg::OP_BUF_RD, 8'h00, 8'h00, lo);
    xfer(sfp_pkg::OP_BUF_RD, 8'h00, 8'h00, hi);
    v = {hi, lo};
  endtask
endmodule // sfp_host

// *** tb/test_sample_fifo_and_irq_pins.sv ***
// self-checking bench for the sample buffer and its interrupt pins
// assumes the host model and the bound checker; buffer depth cut to 8
module test_sample_fifo_and_irq_pins;
  timeunit 1ns;
  timeprecision 100ps;
  // ==========================================================
  // design signals, named as the ports
  logic        i_ref_clk, i_rst, i_link_clk, i_link_rst, i_sample_valid;
  logic        i_activity_event, i_inactivity_event, i_awake, i_link_req;
  logic        i_external_timebase_select, i_external_trigger_select;
  logic [11:0] i_sample_x, i_sample_y, i_sample_z, i_sample_t;
  logic        o_irq_pin_a, o_irq_pin_a_oe, o_irq_pin_b, o_irq_pin_b_oe;
  logic        o_link_busy, o_link_done;
  logic [1:0]  i_link_op;
  logic [7:0]  i_link_addr, i_link_wdata, o_link_rdata, rv;
  logic [15:0] wv;
  int          fails, num_checks;
  localparam logic [1:0] RD = sfp_pkg::OP_REG_RD;
  localparam logic [1:0] WR = sfp_pkg::OP_REG_WR;
  typedef struct packed {logic [1:0] op; logic [7:0] a, w, e;} row_s;
  // register rows: reset values, unmapped, read-only, threshold set to 2
  row_s rows [10] = '{'{RD, 8'h0b, 8'h00, 8'h00}, '{RD, 8'h28, 8'h00, 8'h00},
    '{RD, 8'h29, 8'h00, 8'h80}, '{RD, 8'h2a, 8'h00, 8'h00}, '{RD, 8'h2b, 8'h00, 8'h00},
    '{WR, 8'h30, 8'h5a, 8'h00}, '{RD, 8'h30, 8'h00, 8'h00}, '{WR, 8'h0b, 8'hff, 8'h00},
    '{RD, 8'h0b, 8'h00, 8'h00}, '{WR, 8'h29, 8'h02, 8'h00}};
  sample_fifo_and_irq_pins #(.DEPTH(8)) sample_fifo_and_irq_pins_i (
    .i_ref_clk, .i_rst, .i_sample_valid, .i_sample_x, .i_sample_y, .i_sample_z,
    .i_sample_t, .i_activity_event, .i_inactivity_event, .i_awake,
    .i_external_timebase_select, .i_external_trigger_select, .o_irq_pin_a,
    .o_irq_pin_a_oe, .o_irq_pin_b, .o_irq_pin_b_oe, .i_link_clk, .i_link_rst,
    .i_link_req, .i_link_op, .i_link_addr, .i_link_wdata, .o_link_busy,
    .o_link_done, .o_link_rdata);
  sfp_host sfp_host_i (.i_link_clk, .i_done(o_link_done), .i_rdata(o_link_rdata),
    .o_req(i_link_req), .o_op(i_link_op), .o_addr(i_link_addr), .o_wdata(i_link_wdata));
  // ==========================================================
  // clocks; link offset keeps its edges clear of core edges
  initial begin
    i_ref_clk = 1'b0;
    forever #2 i_ref_clk = ~i_ref_clk;
  end
  initial begin
    i_link_clk = 1'b0;
    #7;
    forever #16 i_link_clk = ~i_link_clk;
  end
  // ==========================================================
  // tasks
  task automatic chk(input logic [15:0] s, e);
    num_checks++;
    if (s !== e) begin
      fails++;
      $display("[ERR] %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic test_done();
    if (fails == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic rd(input logic [7:0] a);
    sfp_host_i.xfer(RD, a, 8'h00, rv);
    wv = {8'h00, rv};
  endtask
  task automatic wr(input logic [7:0] a, w);
    sfp_host_i.xfer(WR, a, w, rv);
  endtask
  // interrupts routed off before settings change
  task automatic cfg(input logic [7:0] c);
    wr(8'h2a, 8'h00);
    wr(8'h2b, 8'h00);
    wr(8'h28, c);
  endtask
  task automatic word();
    sfp_host_i.word(wv);
  endtask
  task automatic pulse(ref logic s);
    @(posedge i_ref_clk) #1 s = 1'b1;
    @(posedge i_ref_clk) #1 s = 1'b0;
  endtask
  task automatic send(input logic [11:0] x, y, z, t);
    @(posedge i_ref_clk) #1 i_sample_valid = 1'b1;
    i_sample_x = x;
    i_sample_y = y;
    i_sample_z = z;
    i_sample_t = t;
    @(posedge i_ref_clk) #1 i_sample_valid = 1'b0;
    repeat (8) @(posedge i_ref_clk);
  endtask
  task automatic sets(input int n0, cnt);
    for (int n = n0; n < n0 + cnt; n++)
      send(12'(16 + n), 12'(32 + n), 12'(48 + n), 12'h000);
  endtask
  // undriven pins are masked: their level is not defined
  task automatic pins(input logic [3:0] e);
    repeat (12) @(posedge i_ref_clk);
    chk(16'({o_irq_pin_a_oe, o_irq_pin_a_oe & o_irq_pin_a, o_irq_pin_b_oe,
             o_irq_pin_b_oe & o_irq_pin_b}), 16'(e));
  endtask
  // ==========================================================
  // watchdog: the run needs about 16 us
  initial begin
    #150000;
    fails++;
    test_done();
  end
  initial begin
    {i_sample_valid, i_activity_event, i_inactivity_event, i_awake} = 4'h0;
    {i_external_timebase_select, i_external_trigger_select} = 2'h0;
    {i_sample_x, i_sample_y, i_sample_z, i_sample_t} = 48'h0;
    i_rst = 1'b1;
    i_link_rst = 1'b1;
    repeat (2) @(posedge i_link_clk);
    #1 {i_rst, i_link_rst} = 2'b00;
    foreach (rows[i]) begin
      sfp_host_i.xfer(rows[i].op, rows[i].a, rows[i].w, rv);
      if (rows[i].op == RD)
        chk(16'(rv), 16'(rows[i].e));
    end
    // stream with temperature, threshold 2
    cfg(8'h06);
    send(12'h801, 12'h123, 12'h7ff, 12'h0f0);
    rd(8'h0b);
    chk(wv, 16'h0007);
    rd(8'h08);
    chk(wv, 16'h0000);
    rd(8'h0b);
    chk(wv, 16'h0006);
    wr(8'h2a, 8'h04);
    pins(4'b1100);
    word();
    chk(wv, 16'h3801);
    word();
    chk(wv, 16'h4123);
    rd(8'h0b);
    chk(wv, 16'h0006);
    word();
    chk(wv, 16'h87ff);
    rd(8'h0b);
    chk(wv, 16'h0002);
    pins(4'b1000);
    wr(8'h2a, 8'h86);
    pins(4'b1000);
    @(posedge i_ref_clk) #1 i_external_timebase_select = 1'b1;
    pins(4'b0000);
    @(posedge i_ref_clk) #1 i_external_timebase_select = 1'b0;
    wr(8'h2a, 8'h82);
    pins(4'b1000);
    word();
    chk(wv, 16'hc0f0);
    word();
    chk(wv, 16'h0000);
    rd(8'h0b);
    chk(wv, 16'h0000);
    pins(4'b1100);
    // threshold with and without the high count bit
    wr(8'h29, 8'h00);
    cfg(8'h0e);
    rd(8'h0b);
    chk(wv, 16'h0000);
    cfg(8'h06);
    rd(8'h0b);
    chk(wv, 16'h0004);
    pins(4'b0000);
    // activity and inactivity on pin b
    wr(8'h2b, 8'h30);
    @(posedge i_ref_clk) #1 i_awake = 1'b1;
    pulse(i_activity_event);
    pins(4'b0011);
    rd(8'h0b);
    chk(wv & 16'h0070, 16'h0050);
    pins(4'b0010);
    pulse(i_inactivity_event);
    pins(4'b0011);
    @(posedge i_ref_clk) #1 i_external_trigger_select = 1'b1;
    pins(4'b0000);
    @(posedge i_ref_clk) #1 {i_external_trigger_select, i_awake} = 2'b00;
    // oldest saved, then a partial set
    cfg(8'h00);
    wr(8'h29, 8'h80);
    cfg(8'h01);
    sets(0, 3);
    rd(8'h0b);
    chk(wv & 16'h000f, 16'h000b);
    word();
    chk(wv, 16'h0010);
    rd(8'h0b);
    chk(wv & 16'h0008, 16'h0000);
    sets(3, 1);
    repeat (7) word();
    word();
    chk(wv, 16'h0013);
    // disable, then stream drop
    cfg(8'h00);
    rd(8'h0b);
    chk(wv & 16'h000e, 16'h0000);
    word();
    chk(wv, 16'h0000);
    cfg(8'h02);
    sets(0, 3);
    rd(8'h0b);
    chk(wv & 16'h000e, 16'h000a);
    word();
    chk(wv, 16'h4020);
    // triggered capture around activity
    cfg(8'h00);
    wr(8'h29, 8'h02);
    cfg(8'h03);
    sets(0, 3);
    pulse(i_activity_event);
    sets(3, 3);
    word();
    chk(wv, 16'h4022);
    // reset in mid-run
    @(posedge i_link_clk) #1 {i_rst, i_link_rst} = 2'b11;
    repeat (2) @(posedge i_link_clk);
    #1 {i_rst, i_link_rst} = 2'b00;
    pins(4'b0000);
    rd(8'h28);
    chk(wv, 16'h0000);
    test_done();
  end
endmodule // test_sample_fifo_and_irq_pins
